// file: rtl/tmr_pkg.sv
// constants for the 16-bit timer with timer, event and window modes
//
// Overview of operation
// R1 - one control register, one 16-bit compare register
// R2 - compare written low then high, else ignored; in warm-up a lone high write still loads the high byte
// R3 - old compare value used until high written
// R4 - software changes mode/source only while stopped
// R5 - software loads compare above one
// R6 - control bits 7, 6, 1 are not reliable
// R7 - stop power mode clears the run bit
// R8 - three modes: timer, event, window
// R9 - timer mode can time oscillator warm-up
// R10 - timer counts internal clock, match clears, interrupts
// R11 - warm-up match uses upper five compare bits
// R12 - high-frequency source only timer mode, slow two
// R13 - event mode counts rising pin edges
// R14 - event match detected on falling pin edge
// R15 - pin levels held at least two cycles
// R16 - window mode counts internal clock while pin high
// R17 - gate pin much slower than counting clock
// R18 - window mode stopped before slow or sleep
// R19 - reset clears run, counter and interrupt
package tmr_pkg;

    // register indices on the 3-bit address port
    localparam logic [2:0] ADDR_CTRL     = 3'h0;
    localparam logic [2:0] ADDR_CMP_LOW  = 3'h1;
    localparam logic [2:0] ADDR_CMP_HIGH = 3'h2;
    localparam logic [2:0] ADDR_CNT_LOW  = 3'h3;
    localparam logic [2:0] ADDR_CNT_HIGH = 3'h4;

    // control register fields
    localparam int RUN_BIT    = 5;
    localparam int SRC_MSB    = 4;
    localparam int SRC_LSB    = 2;
    localparam int WINDOW_BIT = 0;
    // bits 7, 6 and 1 read as zero
    localparam logic [7:0] CTRL_READ_MASK = 8'h3D;
    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // source clock selection codes
    localparam logic [2:0] SRC_SLOWEST = 3'h0;
    localparam logic [2:0] SRC_SLOW    = 3'h1;
    localparam logic [2:0] SRC_MID     = 3'h2;
    localparam logic [2:0] SRC_FAST    = 3'h3;
    localparam logic [2:0] SRC_FC      = 3'h4;
    localparam logic [2:0] SRC_FS      = 3'h5;
    localparam logic [2:0] SRC_PIN     = 3'h7;

    // prescaler tap exponents (fc divided by 2^n, fs divided by 2^n)
    localparam int FC_DIV_SLOWEST = 23;
    localparam int FC_DIV_SLOW    = 13;
    localparam int FC_DIV_MID     = 8;
    localparam int FC_DIV_FAST    = 3;
    localparam int FS_DIV_SLOWEST = 15;
    localparam int FS_DIV_SLOW    = 5;

    // counter and warm-up compare layout
    localparam int CNT_W     = 16;
    localparam int WARM_LSB  = 11;
    localparam logic [15:0] CMP_RESET = 16'h0000;

endpackage

// file: rtl/tmr_prescaler.sv
// free-running dividers giving one-cycle count enables for the timer
`timescale 1ns/100ps
module tmr_prescaler #(
    parameter int FC_W = 24,
    parameter int FS_W = 16
) (
    // clock and reset
    input  wire logic       CLOCK_I,
    input  wire logic       RST_N_I,
    // low-frequency tick, already synchronised
    input  wire logic       fs_tick_i,
    // tap selection
    input  wire logic [2:0] src_i,
    input  wire logic       tap_select_i,
    input  wire logic       slow_i,
    // selected enable pulse
    output logic            tick_o
);

    logic [FC_W-1:0] fc_cnt_r;
    logic [FS_W-1:0] fs_cnt_r;

    // fc divider runs every cycle, fs divider on each fs tick
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            fc_cnt_r <= '0;
        else
            fc_cnt_r <= fc_cnt_r + 1'b1;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            fs_cnt_r <= '0;
        else if (fs_tick_i)
            fs_cnt_r <= fs_cnt_r + 1'b1;
    end

    // a tap fires when the lower n bits are all ones and the divider advances
    function automatic logic fc_tap(input logic [FC_W-1:0] c, input int n);
        logic [FC_W-1:0] m;
        m = (FC_W'(1) << n) - FC_W'(1);
        fc_tap = ((c & m) == m);
    endfunction

    function automatic logic fs_tap(input logic [FS_W-1:0] c, input int n);
        logic [FS_W-1:0] m;
        m = (FS_W'(1) << n) - FS_W'(1);
        fs_tap = ((c & m) == m) && fs_tick_i;
    endfunction

    // in slow modes the two slowest taps fall back to fs, the mid and fast taps stop, fc itself stays on
    always_comb
    begin
        tick_o = 1'b0;
        unique case (src_i)
            tmr_pkg::SRC_SLOWEST:
                tick_o = (slow_i || tap_select_i) ? fs_tap(fs_cnt_r, tmr_pkg::FS_DIV_SLOWEST)
                                                  : fc_tap(fc_cnt_r, tmr_pkg::FC_DIV_SLOWEST);
            tmr_pkg::SRC_SLOW:
                tick_o = (slow_i || tap_select_i) ? fs_tap(fs_cnt_r, tmr_pkg::FS_DIV_SLOW)
                                                  : fc_tap(fc_cnt_r, tmr_pkg::FC_DIV_SLOW);
            tmr_pkg::SRC_MID:
                tick_o = !slow_i && fc_tap(fc_cnt_r, tmr_pkg::FC_DIV_MID);
            tmr_pkg::SRC_FAST:
                tick_o = !slow_i && fc_tap(fc_cnt_r, tmr_pkg::FC_DIV_FAST);
            tmr_pkg::SRC_FC:
                tick_o = 1'b1;
            tmr_pkg::SRC_FS:
                tick_o = fs_tick_i;
            default:
                tick_o = 1'b0;
        endcase
    end

endmodule // tmr_prescaler

// file: rtl/timer_event_window_counter.sv
// 16-bit up-counter timer: internal timer, event counter and window modes
`timescale 1ns/100ps
module timer_event_window_counter (
    // clock and reset
    input  wire logic       CLOCK_I,
    input  wire logic       RST_N_I,
    // register port
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // power mode state from the clock controller
    input  wire logic       STOP_MODE_I,
    input  wire logic       SLOW_MODE_ONE_I,
    input  wire logic       SLOW_MODE_TWO_I,
    input  wire logic       SLEEP_MODE_I,
    input  wire logic       PRESCALER_TAP_SELECT_I,
    // external pins
    input  wire logic       LOW_CLK_I,
    input  wire logic       EVENT_GATE_PIN_I,
    // event and status
    output logic            MATCH_INTERRUPT_O,
    output logic            RUN_BIT_O
);

    typedef enum logic [1:0] {
        MODE_TIMER  = 2'b00,
        MODE_EVENT  = 2'b01,
        MODE_WINDOW = 2'b11
    } mode_e;

    // limitation: the count is read a byte at a time, so a running
    // counter may carry between the low and the high read
    // registers
    logic [7:0]  timer_control_reg_r;
    logic [15:0] compare_value_r;
    logic [7:0]  compare_value_low_r;
    logic        low_pending_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        match_interrupt_r;
    logic [7:0]  rdata_r;

    // synchronisers for the pins
    logic [1:0]  pin_sync_r;
    logic        pin_prev_r;
    logic [1:0]  lck_sync_r;
    logic        lck_prev_r;

    logic        run;
    logic [2:0]  src;
    logic [2:0]  src_eff;
    mode_e       mode;
    logic        slow;
    logic        warm;
    logic        tick;
    logic        fs_tick;
    logic        pin_rise;
    logic        pin_fall;
    logic        cmp_hit;
    logic        advance;
    logic        match;

    assign run  = timer_control_reg_r[tmr_pkg::RUN_BIT];
    assign src  = timer_control_reg_r[tmr_pkg::SRC_MSB:tmr_pkg::SRC_LSB];
    assign slow = SLOW_MODE_ONE_I || SLOW_MODE_TWO_I || SLEEP_MODE_I;

    // mode decode: pin source means event mode regardless of window bit
    always_comb
    begin
        if (src == tmr_pkg::SRC_PIN)
            mode = MODE_EVENT;                                  // see R8, R13
        else if (timer_control_reg_r[tmr_pkg::WINDOW_BIT])
            mode = MODE_WINDOW;                                 // see R8, R16
        else
            mode = MODE_TIMER;                                  // see R8, R10
    end

    // fc source is a warm-up timer in slow mode two only
    assign warm = (mode == MODE_TIMER) && (src == tmr_pkg::SRC_FC)
                  && SLOW_MODE_TWO_I;                           // see R9, R11, R12

    // compare, optionally ignoring the low 11 bits during warm-up
    function automatic logic is_match(input logic [15:0] c,
                                      input logic [15:0] r,
                                      input logic        w);
        if (w)
            is_match = (c[15:tmr_pkg::WARM_LSB] == r[15:tmr_pkg::WARM_LSB]);
        else
            is_match = (c == r);
    endfunction

    // write strobe aimed at one register index
    function automatic logic wr_sel(input logic [2:0] a);
        wr_sel = WR_I && (ADDR_I == a);
    endfunction

    // two flops before anything looks at the pins
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            pin_sync_r <= 2'b00;
            pin_prev_r <= 1'b0;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[0], EVENT_GATE_PIN_I};
            pin_prev_r <= pin_sync_r[1];
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            lck_sync_r <= 2'b00;
            lck_prev_r <= 1'b0;
        end
        else
        begin
            lck_sync_r <= {lck_sync_r[0], LOW_CLK_I};
            lck_prev_r <= lck_sync_r[1];
        end
    end

    // edges of the synchronised pins; pulses need two cycles per level
    assign pin_rise = pin_sync_r[1] && !pin_prev_r;             // see R15
    assign pin_fall = !pin_sync_r[1] && pin_prev_r;
    assign fs_tick  = lck_sync_r[1] && !lck_prev_r;

    // fc source outside warm-up is steered to a code that never ticks
    always_comb
    begin
        if (src == tmr_pkg::SRC_FC && !warm)
            src_eff = tmr_pkg::SRC_PIN;                         // see R12
        else
            src_eff = src;
    end

    // dividers and tap selection
    tmr_prescaler #(
        .FC_W (24),
        .FS_W (16)
    ) u_prescaler (
        .CLOCK_I      (CLOCK_I),
        .RST_N_I      (RST_N_I),
        .fs_tick_i    (fs_tick),
        .src_i        (src_eff),
        .tap_select_i (PRESCALER_TAP_SELECT_I),
        .slow_i       (slow),
        .tick_o       (tick)
    );

    // count enable per mode
    always_comb
    begin
        advance = 1'b0;
        unique case (mode)
            MODE_TIMER:
                advance = tick;                                 // see R10
            MODE_WINDOW:
                // gate pin sampled, much slower than tick by contract
                advance = tick && pin_sync_r[1]
                          && !slow;                             // see R16, R17, R18
            MODE_EVENT:
                advance = pin_rise;                             // see R13
        endcase
    end

    // next count and match decision; clearing on a match restarts the period
    always_comb
    begin
        match     = 1'b0;
        count_nxt = count_r;
        cmp_hit   = is_match(count_r + 16'h0001, compare_value_r, warm);
        if (!run)
            count_nxt = 16'h0000;                               // see R19
        else if (mode == MODE_EVENT)
        begin
            // match is checked on the falling edge after reaching compare
            if (pin_fall && is_match(count_r, compare_value_r, 1'b0))
            begin
                match     = 1'b1;                               // see R14
                count_nxt = 16'h0000;
            end
            else if (advance)
                count_nxt = count_r + 16'h0001;
        end
        else if (advance)
        begin
            if (cmp_hit)
            begin
                match     = 1'b1;                               // see R10, R11, R16
                count_nxt = 16'h0000;
            end
            else
                count_nxt = count_r + 16'h0001;
        end
    end

    // up-counter
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            count_r <= 16'h0000;                                // see R19
        else
            count_r <= count_nxt;
    end

    // interrupt pulse, one cycle per match
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            match_interrupt_r <= 1'b0;                          // see R19
        else
            match_interrupt_r <= match;
    end

    // control register; stop power mode wins over a software write
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            timer_control_reg_r <= tmr_pkg::CTRL_RESET;         // see R19
        else
        begin
            if (wr_sel(tmr_pkg::ADDR_CTRL))
                timer_control_reg_r <= WDATA_I;                 // see R1
            if (STOP_MODE_I)
                timer_control_reg_r[tmr_pkg::RUN_BIT] <= 1'b0;  // see R7
        end
    end

    // staged low byte, only a copy until the high byte lands
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            compare_value_low_r <= 8'h00;
        else if (wr_sel(tmr_pkg::ADDR_CMP_LOW))
            compare_value_low_r <= WDATA_I;                     // see R3
    end

    // pending flag: set by a low write, spent by the next high write
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            low_pending_r <= 1'b0;
        else if (wr_sel(tmr_pkg::ADDR_CMP_LOW))
            low_pending_r <= 1'b1;
        else if (wr_sel(tmr_pkg::ADDR_CMP_HIGH))
            low_pending_r <= 1'b0;
    end

    // committed compare value; matching never sees a half-written pair
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            compare_value_r <= tmr_pkg::CMP_RESET;
        else if (wr_sel(tmr_pkg::ADDR_CMP_HIGH))
        begin
            // a lone high write only counts for warm-up timing
            if (low_pending_r)
                compare_value_r <= {WDATA_I, compare_value_low_r};  // see R1, R2
            else if (warm)
                compare_value_r <= {WDATA_I, compare_value_r[7:0]}; // see R11
        end
    end

    // read data, valid the cycle after the strobe
    // zero when idle, so a stray sample shows up as 00
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            rdata_r <= 8'h00;
        else if (RD_I)
        begin
            unique case (ADDR_I)
                tmr_pkg::ADDR_CTRL:
                    rdata_r <= timer_control_reg_r & tmr_pkg::CTRL_READ_MASK; // see R6
                tmr_pkg::ADDR_CMP_LOW:
                    rdata_r <= compare_value_r[7:0];
                tmr_pkg::ADDR_CMP_HIGH:
                    rdata_r <= compare_value_r[15:8];
                tmr_pkg::ADDR_CNT_LOW:
                    rdata_r <= count_r[7:0];
                tmr_pkg::ADDR_CNT_HIGH:
                    rdata_r <= count_r[15:8];
                default:
                    rdata_r <= 8'h00;
            endcase
        end
        else
            rdata_r <= 8'h00;
    end

    // outputs straight from flops
    assign RDATA_O           = rdata_r;
    assign MATCH_INTERRUPT_O = match_interrupt_r;
    assign RUN_BIT_O         = run;

endmodule // timer_event_window_counter

// file: testbench/tmr_pin_model.sv
// far-side model driving the event or gate pin
`timescale 1ns/100ps
module tmr_pin_model (
    // clock
    input  wire logic clock_i,
    // pin level
    output logic      pin_o
);
    initial pin_o = 1'b0;

    // one event pulse, each level held well beyond two clocks
    task pulse(input int hi, input int lo);
        @(posedge clock_i);
        pin_o <= 1'b1;
        repeat (hi) @(posedge clock_i);
        pin_o <= 1'b0;
        repeat (lo) @(posedge clock_i);
    endtask

    // gate level changes far slower than the counting clock
    task level(input logic v);
        @(posedge clock_i);
        pin_o <= v;
    endtask
endmodule // tmr_pin_model

// file: testbench/timer_event_window_counter_assertions.sv
// port-level checker for the timer, bound to the top module
`timescale 1ns/100ps
module timer_event_window_counter_assertions (
    // clock and reset
    input wire logic       CLOCK_I,
    input wire logic       RST_N_I,
    // register port
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // mode and status
    input wire logic       STOP_MODE_I,
    input wire logic       MATCH_INTERRUPT_O,
    input wire logic       RUN_BIT_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    property p_stop_clr;
        STOP_MODE_I |=> !RUN_BIT_O;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("run kept in stop");
    property p_run_set;
        WR_I && ADDR_I == tmr_pkg::ADDR_CTRL && WDATA_I[5] && !STOP_MODE_I |=> RUN_BIT_O;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run not set");
    property p_run_clr;
        WR_I && ADDR_I == tmr_pkg::ADDR_CTRL && !WDATA_I[5] |=> !RUN_BIT_O;
    endproperty
    a_run_clr: assert property (p_run_clr) else $error("run not cleared");
    property p_irq_one;
        MATCH_INTERRUPT_O |=> !MATCH_INTERRUPT_O;
    endproperty
    a_irq_one: assert property (p_irq_one) else $error("interrupt too long");
    // a stopped counter sits at zero, so no match can follow
    property p_irq_stopped;
        !RUN_BIT_O [*4] |-> !MATCH_INTERRUPT_O;
    endproperty
    a_irq_stopped: assert property (p_irq_stopped) else $error("interrupt while stopped");
    property p_rd_idle;
        !$past(RD_I) |-> RDATA_O == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_ctrl_loose;
        RD_I && ADDR_I == tmr_pkg::ADDR_CTRL |=> (RDATA_O & ~tmr_pkg::CTRL_READ_MASK) == 8'h00;
    endproperty
    a_ctrl_loose: assert property (p_ctrl_loose) else $error("loose bits set");
    property p_unmapped;
        RD_I && ADDR_I > 3'h4 |=> RDATA_O == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule // timer_event_window_counter_assertions

bind timer_event_window_counter timer_event_window_counter_assertions
    u_timer_event_window_counter_assertions (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .STOP_MODE_I(STOP_MODE_I),
    .MATCH_INTERRUPT_O(MATCH_INTERRUPT_O), .RUN_BIT_O(RUN_BIT_O));

// file: testbench/timer_event_window_counter_tb.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/100ps
module timer_event_window_counter_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       stop_m = 1'b0;
    logic       slow_mode_two = 1'b0;
    logic       tapsel = 1'b0;
    logic       lck = 1'b0;
    logic       pin;
    logic [7:0] rdata;
    logic       irq;
    logic       run;
    int         n_errors = 0;
    int         total_checks = 0;
    int         n_irq = 0;
    int         cyc = 0;
    int         k;

    // 50 MHz system clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    tmr_pin_model u_tmr_pin_model (.clock_i(clk), .pin_o(pin));

    // slow mode one and sleep stay low
    timer_event_window_counter u_timer_event_window_counter (
        .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .STOP_MODE_I(stop_m), .SLOW_MODE_ONE_I(1'b0),
        .SLOW_MODE_TWO_I(slow_mode_two), .SLEEP_MODE_I(1'b0), .PRESCALER_TAP_SELECT_I(tapsel),
        .LOW_CLK_I(lck), .EVENT_GATE_PIN_I(pin), .MATCH_INTERRUPT_O(irq),
        .RUN_BIT_O(run));

    // interrupt tally and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        lck <= cyc[2]; // low-frequency clock, 8 system cycles a period
        if (irq === 1'b1)
            n_irq <= n_irq + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task set_cmp(input logic [15:0] v);
        wr_reg(tmr_pkg::ADDR_CMP_LOW, v[7:0]);
        wr_reg(tmr_pkg::ADDR_CMP_HIGH, v[15:8]);
    endtask

    task wait_irq(input int lim);
        int k0;
        k0 = n_irq;
        for (int i = 0; i < lim && n_irq == k0; i++) @(negedge clk);
    endtask

    // prescaler phase is unknown, so measure irq to irq
    task period(input int exp, input int lim);
        int t0;
        wait_irq(lim);
        t0 = cyc;
        wait_irq(lim);
        chk(16'(cyc - t0), 16'(exp));
    endtask

    task t_reset;
        @(negedge clk);
        chk({15'h0, run}, 16'h0);
        rd_reg(tmr_pkg::ADDR_CTRL, 8'h00);
        rd_reg(tmr_pkg::ADDR_CNT_LOW, 8'h00);
    endtask

    task t_pairing;
        wr_reg(tmr_pkg::ADDR_CMP_LOW, 8'h05);
        rd_reg(tmr_pkg::ADDR_CMP_LOW, 8'h00);
        wr_reg(tmr_pkg::ADDR_CMP_HIGH, 8'h01);
        rd_reg(tmr_pkg::ADDR_CMP_LOW, 8'h05);
        wr_reg(tmr_pkg::ADDR_CMP_HIGH, 8'h07);
        rd_reg(tmr_pkg::ADDR_CMP_HIGH, 8'h01);
    endtask

    task t_ctrl;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'hDF);
        rd_reg(tmr_pkg::ADDR_CTRL, 8'h1D);
        rd_reg(3'h5, 8'h00);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
    endtask

    task t_timer_stop;
        set_cmp(16'h0003);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h0C);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h2C);
        period(24, 100);
        @(posedge clk);
        stop_m <= 1'b1;
        @(posedge clk);
        stop_m <= 1'b0;
        @(negedge clk);
        chk({15'h0, run}, 16'h0);
        rd_reg(tmr_pkg::ADDR_CTRL, 8'h0C);
        rd_reg(tmr_pkg::ADDR_CNT_LOW, 8'h00);
    endtask

    task t_window;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h0D);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h2D);
        u_tmr_pin_model.level(1'b1);
        period(24, 100);
        u_tmr_pin_model.level(1'b0);
        repeat (10) @(negedge clk);
        k = n_irq;
        repeat (100) @(negedge clk);
        chk(16'(n_irq - k), 16'h0);
    endtask

    task t_event;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h1C);
        set_cmp(16'h0002);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h3C);
        k = n_irq;
        u_tmr_pin_model.pulse(6, 8);
        rd_reg(tmr_pkg::ADDR_CNT_LOW, 8'h01);
        chk(16'(n_irq - k), 16'h0);
        u_tmr_pin_model.pulse(6, 8);
        chk(16'(n_irq - k), 16'h1);
        rd_reg(tmr_pkg::ADDR_CNT_LOW, 8'h00);
    endtask

    // fs based sources, then a reset while running
    task t_fs;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
        set_cmp(16'h0002);
        @(posedge clk);
        tapsel <= 1'b1;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h04);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h24);
        period(512, 1200);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
        tapsel <= 1'b0;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h14);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h34);
        period(16, 100);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({15'h0, run}, 16'h0);
        rd_reg(tmr_pkg::ADDR_CNT_LOW, 8'h00);
        rd_reg(tmr_pkg::ADDR_CMP_LOW, 8'h00);
    endtask

    task t_warm;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
        @(posedge clk);
        slow_mode_two <= 1'b1;
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h10);
        wr_reg(tmr_pkg::ADDR_CMP_HIGH, 8'h10);
        rd_reg(tmr_pkg::ADDR_CMP_HIGH, 8'h10);
        wr_reg(tmr_pkg::ADDR_CTRL, 8'h30);
        period(4096, 5000);
    endtask

    task tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // reset, then each scenario in turn
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_pairing();
        t_ctrl();
        t_timer_stop();
        t_window();
        t_event();
        t_fs();
        t_warm();
        tally_and_finish();
    end
endmodule // timer_event_window_counter_tb
